// *** design/acr_consts.svh ***
// named constants for the converter configuration register block
// assumes inclusion by bare name from every design file that needs it
`ifndef ACR_CONSTS_SVH
`define ACR_CONSTS_SVH

// register map and reset
`define ACR_RS_CONFIG 3'h2
`define ACR_CFG_RESET 24'h00_0117
`define ACR_CFG_WRITE_MASK 24'h97_FFDF

// communications byte layout
`define ACR_CMD_WEN_BIT 7
`define ACR_CMD_RD_BIT 6
`define ACR_RS_MSB 5
`define ACR_RS_LSB 3

// configuration field positions
`define ACR_CHOP_BIT 23
`define ACR_REFERENCE_SOURCE_SELECT_BIT 20
`define ACR_PSEUDO_BIT 18
`define ACR_SHORT_BIT 17
`define ACR_TEMP_BIT 16
`define ACR_CH_MSB 15
`define ACR_CH_LSB 8
`define ACR_BURN_BIT 7
`define ACR_REFERENCE_MISSING_DETECT_ENABLE_BIT 6
`define ACR_BUF_BIT 4
`define ACR_UNIPOLAR_BIT 3
`define ACR_GAIN_MSB 2
`define ACR_GAIN_LSB 0

// serial bit counts and the channel count
`define ACR_CMD_LAST 5'h07
`define ACR_DATA_LAST 5'h17
`define ACR_RESET_ONES 6'h28
`define ACR_NUM_CHANNELS 8

// timing, filter word 96 with sinc4
`define ACR_CLK_HZ 10000000
`define ACR_MS_PER_S 1000
`define ACR_CONV_NOCHOP_MS 20
`define ACR_SETTLE_NOCHOP_MS 80
`define ACR_CONV_CHOP_MS 80
`define ACR_SETTLE_CHOP_MS 160

`endif

// *** design/acr_pkg.sv ***
// types shared by the configuration register block
// assumes nothing beyond a SystemVerilog compiler
package acr_pkg;

   // serial engine states, gray along cmd -> wr/rd
   typedef enum logic [1:0] {
      acr_st_cmd = 2'b00,
      acr_st_wr = 2'b01,
      acr_st_rd = 2'b10
   } acr_state_t;

endpackage

// *** design/acr_seq.sv ***
// channel sequencer with chop dependent conversion and settling timing
// assumes restart pulses whenever the configuration is rewritten
`include "acr_consts.svh"

module acr_seq #(
   parameter logic [23:0] CONV_NOCHOP = 24'h00_0001,
   parameter logic [23:0] SETTLE_NOCHOP = 24'h00_0001,
   parameter logic [23:0] CONV_CHOP = 24'h00_0001,
   parameter logic [23:0] SETTLE_CHOP = 24'h00_0001
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic restart,
   input wire logic [7:0] channel_enable_bits,
   input wire logic chop_enable,
   output logic [2:0] active_channel,
   output logic conversion_done,
   output logic settling
);

   logic [23:0] cnt;
   logic [23:0] next_cnt;
   logic [2:0] next_chan;
   logic next_settle;
   logic next_done;
   logic [23:0] target;
   logic [2:0] nxt;

   // first enabled channel after cur, wrapping
   function automatic logic [2:0] acr_next_chan(input logic [7:0] en, input logic [2:0] cur);
      logic [2:0] res;
      logic [2:0] cand;
      logic found;
      res = cur;
      found = 1'b0;
      for (int i = 1; i <= `ACR_NUM_CHANNELS; i++) begin
         cand = cur + 3'(i);
         if (!found && en[cand]) begin
            res = cand;
            found = 1'b1;
         end
      end
      return res;
   endfunction

   always_comb begin
      // chop lengthens both periods
      if (chop_enable) begin
         target = settling ? SETTLE_CHOP : CONV_CHOP;
      end else begin
         target = settling ? SETTLE_NOCHOP : CONV_NOCHOP;
      end
      nxt = acr_next_chan(channel_enable_bits, active_channel);
      next_cnt = cnt + 24'h00_0001;
      next_chan = active_channel;
      next_settle = settling;
      next_done = 1'b0;
      if (restart || channel_enable_bits == 8'h00) begin
         next_cnt = 24'h00_0000;
         next_settle = 1'b1;
         next_chan = acr_next_chan(channel_enable_bits, 3'h7);
      end else if (cnt >= target - 24'h00_0001) begin
         // a channel change costs a full settling period
         next_cnt = 24'h00_0000;
         next_done = 1'b1;
         next_chan = nxt;
         next_settle = (nxt != active_channel);
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cnt <= 24'h00_0000;
         active_channel <= 3'h0;
         settling <= 1'b1;
         conversion_done <= 1'b0;
      end else begin
         cnt <= next_cnt;
         active_channel <= next_chan;
         settling <= next_settle;
         conversion_done <= next_done;
      end
   end

endmodule

// *** design/acr_top.sv ***
// converter configuration register behind a three-wire serial port
// assumes the serial pins are asynchronous to clk_sys and far slower than it
`include "acr_consts.svh"

module acr_top #(
   parameter logic [23:0] CONV_NOCHOP_CYCLES = 24'(`ACR_CONV_NOCHOP_MS * (`ACR_CLK_HZ / `ACR_MS_PER_S)),
   parameter logic [23:0] SETTLE_NOCHOP_CYCLES = 24'(`ACR_SETTLE_NOCHOP_MS * (`ACR_CLK_HZ / `ACR_MS_PER_S)),
   parameter logic [23:0] CONV_CHOP_CYCLES = 24'(`ACR_CONV_CHOP_MS * (`ACR_CLK_HZ / `ACR_MS_PER_S)),
   parameter logic [23:0] SETTLE_CHOP_CYCLES = 24'(`ACR_SETTLE_CHOP_MS * (`ACR_CLK_HZ / `ACR_MS_PER_S))
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic serial_clk,
   input wire logic serial_din,
   input wire logic chip_select_n,
   output logic serial_dout,
   output logic serial_dout_oe,
   output logic chop_enable,
   output logic offset_removal_active,
   output logic reference_source_select,
   output logic pseudo_differential,
   output logic short_enable,
   output logic temp_sensor_enable,
   output logic [7:0] channel_enable_bits,
   output logic burnout_enable,
   output logic reference_missing_detect_enable,
   output logic buffer_enable,
   output logic unipolar,
   output logic [2:0] gain_code,
   output logic [2:0] active_channel,
   output logic conversion_done,
   output logic settling
);

   // two stage synchronisers, plus one more stage of clock for edges
   logic [1:0] sclk_meta;
   logic sclk_prev;
   logic [1:0] din_meta;
   logic [1:0] csn_meta;
   logic sclk_s;
   logic din_s;
   logic csn_s;
   logic sclk_rise;
   logic sclk_fall;

   assign sclk_s = sclk_meta[1];
   assign din_s = din_meta[1];
   assign csn_s = csn_meta[1];
   assign sclk_rise = sclk_s && !sclk_prev;
   assign sclk_fall = !sclk_s && sclk_prev;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sclk_meta <= 2'h3;
         sclk_prev <= 1'b1;
         din_meta <= 2'h3;
         csn_meta <= 2'h3;
      end else begin
         sclk_meta <= {sclk_meta[0], serial_clk};
         sclk_prev <= sclk_s;
         din_meta <= {din_meta[0], serial_din};
         csn_meta <= {csn_meta[0], chip_select_n};
      end
   end

   // serial engine and the register itself
   acr_pkg::acr_state_t state;
   acr_pkg::acr_state_t next_state;
   logic [4:0] bit_cnt;
   logic [4:0] next_bit_cnt;
   logic [23:0] shift;
   logic [23:0] next_shift;
   logic [23:0] cfg;
   logic [23:0] next_cfg;
   logic [5:0] ones;
   logic [5:0] next_ones;
   logic next_dout;
   logic restart;
   logic next_restart;
   logic [23:0] sh_in;

   always_comb begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_shift = shift;
      next_cfg = cfg;
      next_ones = ones;
      next_dout = serial_dout;
      next_restart = 1'b0;
      sh_in = {shift[22:0], din_s};
      if (csn_s) begin
         // deselect abandons any transfer in progress
         next_state = acr_pkg::acr_st_cmd;
         next_bit_cnt = 5'h00;
         next_ones = 6'h00;
      end else if (sclk_rise) begin
         next_ones = din_s ? ones + 6'h01 : 6'h00;
         next_bit_cnt = bit_cnt + 5'h01;
         unique case (state)
            acr_pkg::acr_st_cmd: begin
               next_shift = sh_in;
               if (bit_cnt == `ACR_CMD_LAST) begin
                  next_bit_cnt = 5'h00;
                  // only a valid command to this register opens a transfer
                  if (!sh_in[`ACR_CMD_WEN_BIT] && sh_in[`ACR_RS_MSB:`ACR_RS_LSB] == `ACR_RS_CONFIG) begin
                     if (sh_in[`ACR_CMD_RD_BIT]) begin
                        next_state = acr_pkg::acr_st_rd;
                        next_shift = cfg;
                     end else begin
                        next_state = acr_pkg::acr_st_wr;
                     end
                  end
               end
            end
            acr_pkg::acr_st_wr: begin
               next_shift = sh_in;
               if (bit_cnt == `ACR_DATA_LAST) begin
                  // reserved bits are stored as zero whatever is sent
                  next_cfg = sh_in & `ACR_CFG_WRITE_MASK;
                  next_restart = 1'b1;
                  next_bit_cnt = 5'h00;
                  next_state = acr_pkg::acr_st_cmd;
               end
            end
            acr_pkg::acr_st_rd: begin
               if (bit_cnt == `ACR_DATA_LAST) begin
                  next_bit_cnt = 5'h00;
                  next_state = acr_pkg::acr_st_cmd;
               end
            end
            default: begin
               next_bit_cnt = 5'h00;
               next_state = acr_pkg::acr_st_cmd;
            end
         endcase
         // forty ones in a row reset the serial side and the register
         if (din_s && ones + 6'h01 == `ACR_RESET_ONES) begin
            next_cfg = `ACR_CFG_RESET;
            next_restart = 1'b1;
            next_ones = 6'h00;
            next_bit_cnt = 5'h00;
            next_state = acr_pkg::acr_st_cmd;
         end
      end else if (sclk_fall && state == acr_pkg::acr_st_rd) begin
         // present on falling edge, host samples on rising edge
         next_dout = shift[23];
         next_shift = {shift[22:0], 1'b0};
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state <= acr_pkg::acr_st_cmd;
         bit_cnt <= 5'h00;
         shift <= 24'h00_0000;
         cfg <= `ACR_CFG_RESET;
         ones <= 6'h00;
         serial_dout <= 1'b1;
         restart <= 1'b1;
      end else begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         shift <= next_shift;
         cfg <= next_cfg;
         ones <= next_ones;
         serial_dout <= next_dout;
         restart <= next_restart;
      end
   end

   // decoded configuration outputs, each from its own flop
   logic next_burn;

   always_comb begin
      next_burn = cfg[`ACR_BURN_BIT] && cfg[`ACR_BUF_BIT] && !cfg[`ACR_CHOP_BIT];
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         serial_dout_oe <= 1'b0;
         chop_enable <= 1'b0;
         offset_removal_active <= 1'b0;
         reference_source_select <= 1'b0;
         pseudo_differential <= 1'b0;
         short_enable <= 1'b0;
         temp_sensor_enable <= 1'b0;
         channel_enable_bits <= 8'h00;
         burnout_enable <= 1'b0;
         reference_missing_detect_enable <= 1'b0;
         buffer_enable <= 1'b0;
         unipolar <= 1'b0;
         gain_code <= 3'h0;
      end else begin
         serial_dout_oe <= !csn_s;
         chop_enable <= cfg[`ACR_CHOP_BIT];
         offset_removal_active <= cfg[`ACR_CHOP_BIT];
         reference_source_select <= cfg[`ACR_REFERENCE_SOURCE_SELECT_BIT];
         pseudo_differential <= cfg[`ACR_PSEUDO_BIT];
         short_enable <= cfg[`ACR_SHORT_BIT];
         temp_sensor_enable <= cfg[`ACR_TEMP_BIT];
         channel_enable_bits <= cfg[`ACR_CH_MSB:`ACR_CH_LSB];
         burnout_enable <= next_burn;
         reference_missing_detect_enable <= cfg[`ACR_REFERENCE_MISSING_DETECT_ENABLE_BIT];
         buffer_enable <= cfg[`ACR_BUF_BIT];
         unipolar <= cfg[`ACR_UNIPOLAR_BIT];
         gain_code <= cfg[`ACR_GAIN_MSB:`ACR_GAIN_LSB];
      end
   end

   // conversion sequencing over enabled channels
   acr_seq #(
      .CONV_NOCHOP(CONV_NOCHOP_CYCLES),
      .SETTLE_NOCHOP(SETTLE_NOCHOP_CYCLES),
      .CONV_CHOP(CONV_CHOP_CYCLES),
      .SETTLE_CHOP(SETTLE_CHOP_CYCLES)
   ) u_seq (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .restart(restart),
      .channel_enable_bits(cfg[`ACR_CH_MSB:`ACR_CH_LSB]),
      .chop_enable(cfg[`ACR_CHOP_BIT]),
      .active_channel(active_channel),
      .conversion_done(conversion_done),
      .settling(settling)
   );

endmodule

// *** verif/acr_host.sv ***
// host model driving the three-wire serial port of the configuration register
// assumes clk_sys as its timebase; link clock idles high, 8 clk_sys per period
module acr_host (
   input wire logic clk_sys,
   input wire logic serial_dout,
   input wire logic serial_dout_oe,
   output logic serial_clk,
   output logic serial_din,
   output logic chip_select_n
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      serial_clk = 1'b1;
      serial_din = 1'b1;
      chip_select_n = 1'b1;
   end

   task automatic half();
      repeat (4) @(negedge clk_sys);
   endtask

   // n bits of v, msb first; rd keeps the last 24 bits seen on dout
   task automatic shift(input logic [39:0] v, input int n, output logic [23:0] rd);
      chip_select_n = 1'b0;
      half();
      for (int i = n - 1; i >= 0; i--) begin
         serial_clk = 1'b0;
         serial_din = v[i];
         half();
         serial_clk = 1'b1;
         half();
         // a released pin reads as the inverse of what it last showed
         rd = {rd[22:0], serial_dout_oe ? serial_dout : ~serial_dout};
      end
      half();
      chip_select_n = 1'b1;
      serial_din = ~serial_din;
      // deselect stands long enough to be seen before any next transfer
      half();
   endtask
endmodule

// *** verif/acr_top_assertions.sv ***
// checker on the ports of the configuration register block
// assumes it is bound onto acr_top
module acr_top_assertions #(
   parameter logic [23:0] CONV_NOCHOP_CYCLES = 24'h00_0014,
   parameter logic [23:0] CONV_CHOP_CYCLES = 24'h00_0050
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic serial_clk,
   input wire logic chip_select_n,
   input wire logic serial_dout,
   input wire logic serial_dout_oe,
   input wire logic chop_enable,
   input wire logic offset_removal_active,
   input wire logic burnout_enable,
   input wire logic buffer_enable,
   input wire logic [7:0] channel_enable_bits,
   input wire logic [2:0] gain_code,
   input wire logic [2:0] active_channel,
   input wire logic conversion_done
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   logic sclk_q;
   logic [3:0] fall_age;
   logic [23:0] gap;
   logic [3:0] next_fall_age;
   logic [23:0] next_gap;
   always_comb begin
      next_fall_age = (sclk_q && !serial_clk) ? 4'h1 : ((fall_age == 4'hf) ? fall_age : fall_age + 4'h1);
      next_gap = conversion_done ? 24'h00_0001 : ((gap == 24'hff_ffff) ? gap : gap + 24'h00_0001);
   end
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sclk_q <= 1'b1;
         fall_age <= 4'hf;
         gap <= 24'hff_ffff;
      end else begin
         sclk_q <= serial_clk;
         fall_age <= next_fall_age;
         gap <= next_gap;
      end
   end
   a_oe_off_idle: assert property (chip_select_n [*4] |-> !serial_dout_oe)
      else $error("dout enabled while deselected");
   a_oe_on_sel: assert property (!chip_select_n [*4] |-> serial_dout_oe)
      else $error("dout not enabled while selected");
   a_dout_after_fall: assert property ($changed(serial_dout) |-> fall_age inside {[1:6]})
      else $error("dout moved away from a falling link clock");
   a_dout_idle_hold: assert property (chip_select_n [*4] |-> $stable(serial_dout))
      else $error("dout moved while deselected");
   a_burn_gated: assert property (burnout_enable |-> buffer_enable && !chop_enable)
      else $error("burnout on without buffer or with chop");
   a_chop_offset: assert property (offset_removal_active == chop_enable)
      else $error("offset removal differs from chop");
   a_done_single: assert property (conversion_done |=> !conversion_done)
      else $error("conversion pulse longer than one cycle");
   a_done_min_gap: assert property (conversion_done |-> gap >= (chop_enable ? CONV_CHOP_CYCLES : CONV_NOCHOP_CYCLES))
      else $error("conversions closer than the conversion time");
   a_done_enabled: assert property (conversion_done |-> channel_enable_bits[active_channel])
      else $error("conversion on a disabled channel");
   a_reset_value: assert property ($rose(resetn) |-> ##[1:2] (gain_code == 3'h7 && buffer_enable && channel_enable_bits == 8'h01))
      else $error("outputs not at reset value after reset");
   c_chop_conv: cover property (conversion_done && chop_enable);
   c_burn_on: cover property (burnout_enable);
   c_dout_fall: cover property (serial_dout_oe && $fell(serial_dout));
endmodule

bind acr_top acr_top_assertions #(
   .CONV_NOCHOP_CYCLES(CONV_NOCHOP_CYCLES),
   .CONV_CHOP_CYCLES(CONV_CHOP_CYCLES)
) u_chk (
   .clk_sys(clk_sys), .resetn(resetn), .serial_clk(serial_clk), .chip_select_n(chip_select_n),
   .serial_dout(serial_dout), .serial_dout_oe(serial_dout_oe), .chop_enable(chop_enable),
   .offset_removal_active(offset_removal_active), .burnout_enable(burnout_enable),
   .buffer_enable(buffer_enable), .channel_enable_bits(channel_enable_bits), .gain_code(gain_code),
   .active_channel(active_channel), .conversion_done(conversion_done)
);

// *** verif/acr_top_test.sv ***
// self-checking bench for the configuration register block
// assumes acr_host as the serial host and short sequencer timing parameters
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fails++; \
   $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end

module acr_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys, resetn, serial_clk, serial_din, chip_select_n, serial_dout, serial_dout_oe;
   logic chop_enable, offset_removal_active, reference_source_select, pseudo_differential;
   logic short_enable, temp_sensor_enable, burnout_enable, reference_missing_detect_enable;
   logic buffer_enable, unipolar, conversion_done, settling;
   logic [7:0] channel_enable_bits;
   logic [2:0] gain_code, active_channel, ch;
   logic [23:0] r;
   int fails = 0;
   int comparisons = 0;
   int n;
   logic [23:0] vals[3] = '{24'h14_ff98, 24'h83_02d2, 24'h00_0180};
   logic [23:0] seqv[3] = '{24'h00_0300, 24'h80_0100, 24'h80_0300};
   int gaps[3] = '{80, 80, 160};

   acr_top #(.CONV_NOCHOP_CYCLES(24'h00_0014), .SETTLE_NOCHOP_CYCLES(24'h00_0050),
      .CONV_CHOP_CYCLES(24'h00_0050), .SETTLE_CHOP_CYCLES(24'h00_00a0)) dut (
      .clk_sys(clk_sys), .resetn(resetn), .serial_clk(serial_clk), .serial_din(serial_din),
      .chip_select_n(chip_select_n), .serial_dout(serial_dout), .serial_dout_oe(serial_dout_oe),
      .chop_enable(chop_enable), .offset_removal_active(offset_removal_active),
      .reference_source_select(reference_source_select), .pseudo_differential(pseudo_differential),
      .short_enable(short_enable), .temp_sensor_enable(temp_sensor_enable),
      .channel_enable_bits(channel_enable_bits), .burnout_enable(burnout_enable),
      .reference_missing_detect_enable(reference_missing_detect_enable), .buffer_enable(buffer_enable),
      .unipolar(unipolar), .gain_code(gain_code), .active_channel(active_channel),
      .conversion_done(conversion_done), .settling(settling));
   acr_host host (.clk_sys(clk_sys), .serial_dout(serial_dout), .serial_dout_oe(serial_dout_oe),
      .serial_clk(serial_clk),
      .serial_din(serial_din), .chip_select_n(chip_select_n));

   initial clk_sys = 1'b0;
   always #50 clk_sys = ~clk_sys;

   function automatic logic [23:0] outs();
      return {chop_enable, 2'b00, reference_source_select, 1'b0, pseudo_differential, short_enable,
         temp_sensor_enable, channel_enable_bits, burnout_enable, reference_missing_detect_enable,
         1'b0, buffer_enable, unipolar, gain_code};
   endfunction

   task automatic close_out();
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic rst();
      resetn = 1'b0;
      repeat (20) @(negedge clk_sys);
      resetn = 1'b1;
      repeat (4) @(negedge clk_sys);
      `CHK(outs(), 24'h00_0117)
   endtask

   task automatic rd_chk(input logic [23:0] e);
      host.shift({16'h0050, 24'h00_0000}, 32, r);
      `CHK(r, e)
   endtask

   task automatic wait_done();
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (conversion_done !== 1'b1 && n < 2000);
      if (n >= 2000) begin
         fails++;
         close_out();
      end
   endtask

   initial begin
      resetn = 1'b0;
      rst();
      rd_chk(24'h00_0117);
      wait_done();
      wait_done();
      `CHK(n, 20)
      foreach (vals[i]) begin
         host.shift({16'h0010, vals[i]}, 32, r);
         repeat (4) @(negedge clk_sys);
         `CHK(outs(), {vals[i][23:8], vals[i][7] & vals[i][4] & ~vals[i][23], vals[i][6:0]})
         `CHK(offset_removal_active, vals[i][23])
         rd_chk(vals[i]);
      end
      host.shift({16'h0018, 24'h00_0000}, 32, r);
      // write cut short by deselect after 12 data bits
      host.shift(40'h00_0001_0abc, 20, r);
      rd_chk(vals[2]);
      host.shift(40'hff_ffff_ffff, 40, r);
      repeat (4) @(negedge clk_sys);
      `CHK(outs(), 24'h00_0117)
      foreach (seqv[i]) begin
         host.shift({16'h0010, seqv[i]}, 32, r);
         wait_done();
         ch = active_channel;
         `CHK(settling, seqv[i][9])
         wait_done();
         `CHK(n, gaps[i])
         `CHK(active_channel, seqv[i][9] ? ch ^ 3'h1 : ch)
      end
      rst();
      close_out();
   end
endmodule
